// file: ipssel_pkg.sv
/*
 Constants, field layouts and enumerations of the peripheral input source select block.
 Assumes the registers sit on an AHB-Lite bus, one aligned word for each register index.
*/
// Contract
// [RULE1] Fault two: pin when clear, comparator B when set
// [RULE2] Fault one: pin when clear, comparator A when set
// [RULE3] Pair two: timer three, ADC, comparator A, B
// [RULE4] Pair two ADC limits drive fourth/fifth outputs
// [RULE5] Pair one: pin, timer two, ADC, comparators
// [RULE6] Pair one ADC limits drive second/third outputs
// [RULE7] Pair zero: pin, timer zero, ADC, comparators
// [RULE8] Pair zero ADC limits drive zeroth/first outputs
// [RULE9] DAC one sync: timers, PWM sync, timer channels
// [RULE10] DAC zero sync uses DAC one encoding
// [RULE11] Software routes exactly one pin per input
// [RULE12] Software sets pin peripheral enable bit
// [RULE13] Software avoids changes while peripheral runs
// [RULE14] Fields reset zero, reserved bits read zero
// [RULE15] Reserved codes give inactive constant output
package ipssel_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int unsigned REG_W = 16;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned IDX_LSB = 2;
   localparam logic [IDX_W-1:0] PWM_SEL_IDX = 8'h18;
   localparam logic [IDX_W-1:0] DAC_SEL_IDX = 8'h19;
   localparam logic [REG_W-1:0] SEL_RESET = 16'h0000;
   localparam logic [REG_W-1:0] PWM_SEL_MASK = 16'h29FF;
   localparam logic [REG_W-1:0] DAC_SEL_MASK = 16'h0077;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned SEL_W = 3;
   localparam int unsigned FAULT_TWO_BIT = 13;
   localparam int unsigned FAULT_ONE_BIT = 11;
   localparam int unsigned PAIR_TWO_LSB = 6;
   localparam int unsigned PAIR_ONE_LSB = 3;
   localparam int unsigned PAIR_ZERO_LSB = 0;
   localparam int unsigned DAC_ONE_LSB = 4;
   localparam int unsigned DAC_ZERO_LSB = 0;

   // ****************************************************************
   // Bus constants
   // ****************************************************************
   localparam int unsigned HTRANS_ACT_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   typedef enum logic [SEL_W-1:0] {
      PAIR_PIN = 3'h0,
      PAIR_TIMER = 3'h1,
      PAIR_ADC = 3'h2,
      PAIR_CMP_A = 3'h3,
      PAIR_CMP_B = 3'h4
   } ipssel_pair_e;

   typedef enum logic [SEL_W-1:0] {
      DSYNC_ITMR0 = 3'h0,
      DSYNC_ITMR1 = 3'h1,
      DSYNC_ITMR2 = 3'h2,
      DSYNC_PWM = 3'h3,
      DSYNC_TMR0 = 3'h4,
      DSYNC_TMR1 = 3'h5
   } ipssel_dsync_e;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_RWAIT = 2'b01,
      BUS_RDONE = 2'b11
   } ipssel_bus_e;

endpackage : ipssel_pkg

// file: ipssel_reg_if.sv
/*
 Carrier between the bus slave and the register file.
 Assumes one clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
interface ipssel_reg_if;
   import ipssel_pkg::*;
   logic wr_pwm;
   logic wr_dac;
   logic [REG_W-1:0] wr_data;
   logic [REG_W-1:0] pwm_word;
   logic [REG_W-1:0] dac_word;

   modport bus
   (
      output wr_pwm,
      output wr_dac,
      output wr_data,
      input pwm_word,
      input dac_word
   );

   modport regs
   (
      input wr_pwm,
      input wr_dac,
      input wr_data,
      output pwm_word,
      output dac_word
   );
endinterface : ipssel_reg_if

// file: ipssel_ahb_slave.sv
/*
 AHB-Lite slave front end: writes with no wait state, reads with one.
 Assumes single word transfers; any word index in haddr[9:2] outside the map reads zero, higher address bits are not decoded.
*/
`timescale 1ns/1ps
module ipssel_ahb_slave
   import ipssel_pkg::*;
(
   input logic hclk,
   input logic hresetn,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   ipssel_reg_if.bus rif
);

   // ****************************************************************
   // Address phase decode
   // ****************************************************************
   ipssel_bus_e st_q;
   ipssel_bus_e st_d;
   logic accept;
   logic hit_pwm;
   logic hit_dac;
   logic wr_pwm_q;
   logic wr_dac_q;
   logic rd_pwm_q;
   logic rd_dac_q;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic hreadyout_q;
   logic hreadyout_d;
   logic [REG_W-1:0] rd_word;

   assign accept = hsel & htrans[HTRANS_ACT_BIT] & hready;
   assign hit_pwm = haddr[IDX_LSB +: IDX_W] == PWM_SEL_IDX;
   assign hit_dac = haddr[IDX_LSB +: IDX_W] == DAC_SEL_IDX;
   assign rd_word = rd_pwm_q ? rif.pwm_word : (rd_dac_q ? rif.dac_word : SEL_RESET);

   // ****************************************************************
   // Data phase control
   // ****************************************************************
   always_comb
   begin
      st_d = st_q;
      hreadyout_d = hreadyout_q;
      hrdata_d = hrdata_q;
      case (st_q)
         BUS_RWAIT:
         begin
            st_d = BUS_RDONE;
            hreadyout_d = 1'b1;
            hrdata_d = {{(32-REG_W){1'b0}}, rd_word};
         end
         BUS_IDLE, BUS_RDONE:
         begin
            st_d = BUS_IDLE;
            if (accept && !hwrite)
            begin
               st_d = BUS_RWAIT;
               hreadyout_d = 1'b0;
            end
         end
         default:
         begin
            st_d = BUS_IDLE;
            hreadyout_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= BUS_IDLE;
         hreadyout_q <= 1'b1;
         hrdata_q <= RDATA_ZERO;
         wr_pwm_q <= 1'b0;
         wr_dac_q <= 1'b0;
         rd_pwm_q <= 1'b0;
         rd_dac_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         hreadyout_q <= hreadyout_d;
         hrdata_q <= hrdata_d;
         wr_pwm_q <= accept & hwrite & hit_pwm;
         wr_dac_q <= accept & hwrite & hit_dac;
         if (accept)
         begin
            rd_pwm_q <= !hwrite & hit_pwm;
            rd_dac_q <= !hwrite & hit_dac;
         end
      end
   end

   assign rif.wr_pwm = wr_pwm_q;
   assign rif.wr_dac = wr_dac_q;
   assign rif.wr_data = hwdata[REG_W-1:0];
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = HRESP_OKAY;

endmodule : ipssel_ahb_slave

// file: ipssel_pair_mux.sv
/*
 Source selection for one PWM pair with registered outputs.
 Assumes the pin input is already synchronised and the others share the clock.
*/
`timescale 1ns/1ps
module ipssel_pair_mux
   import ipssel_pkg::*;
#(
   parameter logic PIN_OK = 1'b1
)
(
   input logic hclk,
   input logic hresetn,
   input logic [SEL_W-1:0] sel,
   input logic pin,
   input logic timer,
   input logic cmp_a,
   input logic cmp_b,
   input logic adc_above,
   input logic adc_below,
   output logic src,
   output logic even,
   output logic odd
);

   // ****************************************************************
   // Selection
   // ****************************************************************
   logic src_q;
   logic even_q;
   logic odd_q;
   logic src_d;
   logic even_d;
   logic odd_d;
   logic use_pin;
   logic use_adc;
   logic code_ok;
   logic sig;

   assign use_pin = (sel == PAIR_PIN) & PIN_OK;
   assign use_adc = sel == PAIR_ADC;
   assign code_ok = use_pin | (sel == PAIR_TIMER) | (sel == PAIR_CMP_A) | (sel == PAIR_CMP_B);
   assign sig = (use_pin & pin) | ((sel == PAIR_TIMER) & timer)
      | ((sel == PAIR_CMP_A) & cmp_a) | ((sel == PAIR_CMP_B) & cmp_b); // [RULE3] [RULE5] [RULE7]
   // Between the limits the pair keeps its last state
   assign src_d = use_adc ? (adc_above | (!adc_below & src_q)) : sig; // [RULE15]
   assign even_d = use_adc ? (!adc_above & (adc_below | even_q)) : (code_ok & sig); // [RULE4] [RULE6] [RULE8]
   assign odd_d = use_adc ? (adc_above | (!adc_below & odd_q)) : (code_ok & !sig); // [RULE15]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src_q <= 1'b0;
         even_q <= 1'b0;
         odd_q <= 1'b0;
      end
      else
      begin
         src_q <= src_d;
         even_q <= even_d;
         odd_q <= odd_d;
      end
   end

   assign src = src_q;
   assign even = even_q;
   assign odd = odd_q;

endmodule : ipssel_pair_mux

// file: ipssel_top.sv
/*
 Peripheral input source select: two selection registers and the multiplexers they drive.
 Assumes an AHB-Lite master on hclk; pins are asynchronous, peripheral signals share hclk.
*/
`timescale 1ns/1ps
module ipssel_top
   import ipssel_pkg::*;
(
   input logic hclk,
   input logic hresetn,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic hready,
   input logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input logic fault_one_pin,
   input logic fault_two_pin,
   input logic pair_zero_pin,
   input logic pair_one_pin,
   input logic comparator_a_output,
   input logic comparator_b_output,
   input logic timer_a_channel_zero,
   input logic timer_a_channel_one,
   input logic timer_a_channel_two,
   input logic timer_a_channel_three,
   input logic [2:0] adc_above_high,
   input logic [2:0] adc_below_low,
   input logic interval_timer_zero,
   input logic interval_timer_one,
   input logic interval_timer_two,
   input logic pwm_reload_sync,
   output logic fault_one_input,
   output logic fault_two_input,
   output logic [2:0] pair_source,
   output logic [2:0] pair_even_out,
   output logic [2:0] pair_odd_out,
   output logic dac_zero_sync,
   output logic dac_one_sync
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic dsync_pick(input logic [SEL_W-1:0] code, input logic [5:0] srcs);
      logic r;
      r = 1'b0;
      case (code)
         DSYNC_ITMR0: r = srcs[0];
         DSYNC_ITMR1: r = srcs[1];
         DSYNC_ITMR2: r = srcs[2];
         DSYNC_PWM: r = srcs[3];
         DSYNC_TMR0: r = srcs[4];
         DSYNC_TMR1: r = srcs[5];
         default: r = 1'b0;
      endcase
      return r;
   endfunction : dsync_pick

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   ipssel_reg_if rif ();

   ipssel_ahb_slave u_bus
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rif(rif)
   );

   // ****************************************************************
   // Selection registers
   // ****************************************************************
   logic [REG_W-1:0] pwm_sel_q;
   logic [REG_W-1:0] pwm_sel_d;
   logic [REG_W-1:0] dac_sel_q;
   logic [REG_W-1:0] dac_sel_d;
   logic unused_size;

   assign unused_size = ^hsize;
   assign pwm_sel_d = rif.wr_pwm ? (rif.wr_data & PWM_SEL_MASK) : pwm_sel_q; // [RULE14]
   assign dac_sel_d = rif.wr_dac ? (rif.wr_data & DAC_SEL_MASK) : dac_sel_q; // [RULE14]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pwm_sel_q <= SEL_RESET; // [RULE14]
         dac_sel_q <= SEL_RESET;
      end
      else
      begin
         pwm_sel_q <= pwm_sel_d;
         dac_sel_q <= dac_sel_d;
      end
   end

   assign rif.pwm_word = pwm_sel_q;
   assign rif.dac_word = dac_sel_q;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta_q <= 4'h0;
         pin_sync_q <= 4'h0;
      end
      else
      begin
         pin_meta_q <= {pair_one_pin, pair_zero_pin, fault_two_pin, fault_one_pin};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ****************************************************************
   // Fault and DAC sync selection
   // ****************************************************************
   logic fault_one_q;
   logic fault_two_q;
   logic dac_zero_q;
   logic dac_one_q;
   logic fault_one_d;
   logic fault_two_d;
   logic dac_zero_d;
   logic dac_one_d;
   logic [5:0] dsync_srcs;

   assign fault_one_d = pwm_sel_q[FAULT_ONE_BIT] ? comparator_a_output : pin_sync_q[0]; // [RULE2]
   assign fault_two_d = pwm_sel_q[FAULT_TWO_BIT] ? comparator_b_output : pin_sync_q[1]; // [RULE1]
   assign dsync_srcs = {timer_a_channel_one, timer_a_channel_zero, pwm_reload_sync,
      interval_timer_two, interval_timer_one, interval_timer_zero};
   assign dac_one_d = dsync_pick(dac_sel_q[DAC_ONE_LSB +: SEL_W], dsync_srcs); // [RULE9] [RULE15]
   assign dac_zero_d = dsync_pick(dac_sel_q[DAC_ZERO_LSB +: SEL_W], dsync_srcs); // [RULE10]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fault_one_q <= 1'b0;
         fault_two_q <= 1'b0;
         dac_zero_q <= 1'b0;
         dac_one_q <= 1'b0;
      end
      else
      begin
         fault_one_q <= fault_one_d;
         fault_two_q <= fault_two_d;
         dac_zero_q <= dac_zero_d;
         dac_one_q <= dac_one_d;
      end
   end

   assign fault_one_input = fault_one_q;
   assign fault_two_input = fault_two_q;
   assign dac_zero_sync = dac_zero_q;
   assign dac_one_sync = dac_one_q;

   // ****************************************************************
   // Pair source selection
   // ****************************************************************
   ipssel_pair_mux #(.PIN_OK(1'b1)) u_pair_zero
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(pwm_sel_q[PAIR_ZERO_LSB +: SEL_W]),
      .pin(pin_sync_q[2]),
      .timer(timer_a_channel_zero),
      .cmp_a(comparator_a_output),
      .cmp_b(comparator_b_output),
      .adc_above(adc_above_high[0]),
      .adc_below(adc_below_low[0]),
      .src(pair_source[0]),
      .even(pair_even_out[0]),
      .odd(pair_odd_out[0])
   );

   ipssel_pair_mux #(.PIN_OK(1'b1)) u_pair_one
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(pwm_sel_q[PAIR_ONE_LSB +: SEL_W]),
      .pin(pin_sync_q[3]),
      .timer(timer_a_channel_two),
      .cmp_a(comparator_a_output),
      .cmp_b(comparator_b_output),
      .adc_above(adc_above_high[1]),
      .adc_below(adc_below_low[1]),
      .src(pair_source[1]),
      .even(pair_even_out[1]),
      .odd(pair_odd_out[1])
   );

   // No pin for pair two; its code zero is reserved
   ipssel_pair_mux #(.PIN_OK(1'b0)) u_pair_two
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(pwm_sel_q[PAIR_TWO_LSB +: SEL_W]),
      .pin(1'b0),
      .timer(timer_a_channel_three),
      .cmp_a(comparator_a_output),
      .cmp_b(comparator_b_output),
      .adc_above(adc_above_high[2]),
      .adc_below(adc_below_low[2]),
      .src(pair_source[2]),
      .even(pair_even_out[2]),
      .odd(pair_odd_out[2])
   );

endmodule : ipssel_top

// file: ipssel_src_model.sv
/*
 Model of the on-chip sources and pins feeding the select block.
 Assumes the bench sets the wanted levels; every source moves on hclk.
*/
`timescale 1ns/1ps
module ipssel_src_model
(
   input logic hclk,
   input logic hresetn,
   input logic [19:0] level,
   output logic [19:0] src
);
   // One pin per routed input, on its own bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src <= 20'h00000;
      end
      else
      begin
         src <= level;
      end
   end
endmodule : ipssel_src_model

// file: ipssel_monitor.sv
/*
 Checker of the source select outputs against shadowed bus writes.
 Assumes one AHB-Lite master with hready tied to hreadyout.
*/
`timescale 1ns/1ps
module ipssel_monitor
   import ipssel_pkg::*;
(
   input logic hclk,
   input logic hresetn,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic [31:0] hwdata,
   input logic hreadyout,
   input logic comparator_a_output,
   input logic comparator_b_output,
   input logic timer_a_channel_one,
   input logic timer_a_channel_three,
   input logic pwm_reload_sync,
   input logic [2:0] adc_above_high,
   input logic [2:0] adc_below_low,
   input logic fault_one_input,
   input logic fault_two_input,
   input logic [2:0] pair_source,
   input logic [2:0] pair_even_out,
   input logic [2:0] pair_odd_out,
   input logic dac_zero_sync,
   input logic dac_one_sync
);
   // ***********************************
   // Shadow registers
   // ***********************************
   logic wr_q;
   logic [7:0] idx_q;
   logic [15:0] pwm_q;
   logic [15:0] dac_q;
   wire take = hsel & htrans[1] & hready;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         idx_q <= 8'h00;
         pwm_q <= 16'h0000;
         dac_q <= 16'h0000;
      end
      else
      begin
         wr_q <= take & hwrite;
         idx_q <= haddr[9:2];
         if (wr_q && hready && idx_q == PWM_SEL_IDX)
            pwm_q <= hwdata[15:0] & 16'h29FF;
         if (wr_q && hready && idx_q == DAC_SEL_IDX)
            dac_q <= hwdata[15:0] & 16'h0077;
      end
   end
   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_fault_two_cmp: assert property (
      $past(pwm_q[13]) |-> fault_two_input == $past(comparator_b_output))
      else $error("fault two source wrong");
   chk_fault_one_cmp: assert property (
      $past(pwm_q[11]) |-> fault_one_input == $past(comparator_a_output))
      else $error("fault one source wrong");
   chk_pair_two_timer: assert property (
      $past(pwm_q[8:6]) == 3'h1 |-> pair_source[2] == $past(timer_a_channel_three))
      else $error("pair two timer wrong");
   chk_pair_two_high: assert property (
      $past(pwm_q[8:6]) == 3'h2 && $past(adc_above_high[2])
      |-> !pair_even_out[2] && pair_odd_out[2])
      else $error("pair two above limit wrong");
   chk_pair_one_cmp: assert property (
      $past(pwm_q[5:3]) == 3'h3 |-> pair_source[1] == $past(comparator_a_output)
      && pair_odd_out[1] != pair_even_out[1])
      else $error("pair one comparator wrong");
   chk_pair_one_low: assert property (
      $past(pwm_q[5:3]) == 3'h2 && $past(adc_below_low[1] & ~adc_above_high[1])
      |-> pair_even_out[1] && !pair_odd_out[1])
      else $error("pair one below limit wrong");
   chk_pair_zero_cmpb: assert property (
      $past(pwm_q[2:0]) == 3'h4 |-> pair_source[0] == $past(comparator_b_output))
      else $error("pair zero comparator wrong");
   chk_pair_zero_high: assert property (
      $past(pwm_q[2:0]) == 3'h2 && $past(adc_above_high[0])
      |-> !pair_even_out[0] && pair_odd_out[0])
      else $error("pair zero above limit wrong");
   chk_dac_one_pwm: assert property (
      $past(dac_q[6:4]) == 3'h3 |-> dac_one_sync == $past(pwm_reload_sync))
      else $error("dac one sync wrong");
   chk_dac_zero_tmr: assert property (
      $past(dac_q[2:0]) == 3'h5 |-> dac_zero_sync == $past(timer_a_channel_one))
      else $error("dac zero sync wrong");
   chk_reserved_quiet: assert property (
      $past(pwm_q[8:6]) > 3'h4 && $past(dac_q[6:5]) == 2'b11
      |-> {pair_source[2], pair_even_out[2], pair_odd_out[2], dac_one_sync} == 4'h0)
      else $error("reserved code not quiet");
   chk_read_wait: assert property (
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   cover property ($past(pwm_q[8:6]) == 3'h2 && $past(adc_above_high[2]));
   cover property ($past(dac_q[6:4]) == 3'h3);
   cover property (take && !hwrite);
endmodule : ipssel_monitor

bind ipssel_top ipssel_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hwdata, .hreadyout, .comparator_a_output, .comparator_b_output,
   .timer_a_channel_one, .timer_a_channel_three, .pwm_reload_sync, .adc_above_high,
   .adc_below_low, .fault_one_input, .fault_two_input, .pair_source, .pair_even_out,
   .pair_odd_out, .dac_zero_sync, .dac_one_sync);

// file: tb_top.sv
/*
 Self-checking bench: bus register access, then every code of every field.
 Assumes the source model drives all peripheral and pin inputs.
*/
`timescale 1ns/1ps
module tb_top
   import ipssel_pkg::*;
;
   localparam logic [31:0] A_PWM = 32'h0000_0060;
   localparam logic [31:0] A_DAC = 32'h0000_0064;
   localparam logic [19:0] PAT = 20'h5_C696;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [19:0] level = 20'h0;
   logic [31:0] rd;
   wire [19:0] s;
   wire [31:0] hrdata;
   wire hreadyout;
   wire hresp;
   wire f1;
   wire f2;
   wire d0;
   wire d1;
   wire [2:0] ps;
   wire [2:0] pe;
   wire [2:0] po;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   always #12.5 hclk = ~hclk;

   ipssel_src_model i_src (.hclk(hclk), .hresetn(hresetn), .level(level), .src(s));
   ipssel_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .fault_one_pin(s[0]), .fault_two_pin(s[1]), .pair_zero_pin(s[2]),
      .pair_one_pin(s[3]), .comparator_a_output(s[4]), .comparator_b_output(s[5]),
      .timer_a_channel_zero(s[6]), .timer_a_channel_one(s[7]),
      .timer_a_channel_two(s[8]), .timer_a_channel_three(s[9]),
      .adc_above_high(s[12:10]), .adc_below_low(s[15:13]), .interval_timer_zero(s[16]),
      .interval_timer_one(s[17]), .interval_timer_two(s[18]), .pwm_reload_sync(s[19]),
      .fault_one_input(f1), .fault_two_input(f2), .pair_source(ps), .pair_even_out(pe),
      .pair_odd_out(po), .dac_zero_sync(d0), .dac_one_sync(d1));

   // ***********************************
   // Tasks
   // ***********************************
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", 32'(hresp), 32'(HRESP_OKAY));
   endtask : xfer

   function automatic logic [2:0] pexp(input int p, input logic [2:0] c,
      input logic [19:0] v);
      logic [4:0] m;
      m = {v[5], v[4], 1'b0, v[p == 0 ? 6 : 7 + p], v[2 + p]};
      if (c == 3'h2)
         return v[10 + p] ? 3'b101 : 3'b010;
      if (c > 3'h4 || (c == 3'h0 && p == 2))
         return 3'b000;
      return {m[c], m[c], ~m[c]};
   endfunction : pexp

   function automatic logic dexp(input logic [2:0] c, input logic [19:0] v);
      logic [5:0] m;
      m = {v[7], v[6], v[19], v[18], v[17], v[16]};
      return (c < 3'h6) ? m[c] : 1'b0;
   endfunction : dexp

   task automatic run_code(input logic [2:0] c);
      logic [15:0] pw;
      logic [15:0] dw;
      pw = {2'b00, c[0], 1'b0, c[0], 2'b00, c, c, c};
      dw = {9'h000, c, 1'b0, c};
      // Selections change only while the sources stand still
      xfer(1'b1, A_PWM, {16'h0, pw});
      xfer(1'b1, A_DAC, {16'h0, dw});
      xfer(1'b0, A_PWM, 32'h0);
      check("pwm word", rd, {16'h0, pw});
      xfer(1'b0, A_DAC, 32'h0);
      check("dac word", rd, {16'h0, dw});
      for (int k = 0; k < 2; k++)
      begin
         level <= k[0] ? ~PAT : PAT;
         repeat (6) @(posedge hclk);
         check("fault one", 32'(f1), 32'(c[0] ? level[4] : level[0]));
         check("fault two", 32'(f2), 32'(c[0] ? level[5] : level[1]));
         for (int p = 0; p < 3; p++)
            check("pair", 32'({ps[p], pe[p], po[p]}), 32'(pexp(p, c, level)));
         check("dac zero", 32'(d0), 32'(dexp(c, level)));
         check("dac one", 32'(d1), 32'(dexp(c, level)));
      end
   endtask : run_code

   task automatic results;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // ***********************************
   // Sequence
   // ***********************************
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, A_PWM, 32'h0);
      check("pwm reset", rd, 32'h0);
      xfer(1'b0, A_DAC, 32'h0);
      check("dac reset", rd, 32'h0);
      xfer(1'b1, A_PWM, 32'hFFFF_FFFF);
      xfer(1'b0, A_PWM, 32'h0);
      check("pwm reserved", rd, 32'h0000_29FF);
      xfer(1'b1, A_DAC, 32'hFFFF_FFFF);
      xfer(1'b0, A_DAC, 32'h0);
      check("dac reserved", rd, 32'h0000_0077);
      xfer(1'b1, 32'h0000_0068, 32'hFFFF_FFFF);
      xfer(1'b0, 32'h0000_0068, 32'h0);
      check("unmapped", rd, 32'h0);
      for (int c = 0; c < 8; c++)
         run_code(c[2:0]);
      results();
   end
endmodule : tb_top
